// ===== common/ppp_pkg.sv
// Package: constants and types of the parallel programming port
package ppp_pkg;

	// Action select coding
	localparam logic [1:0] ACT_ADDR = 2'h0;
	localparam logic [1:0] ACT_DATA = 2'h1;
	localparam logic [1:0] ACT_CMD  = 2'h2;
	localparam logic [1:0] ACT_IDLE = 2'h3;

	// Command bytes
	localparam logic [7:0] CMD_NOP       = 8'h00;
	localparam logic [7:0] CMD_ERASE     = 8'h80;
	localparam logic [7:0] CMD_WR_FUSE   = 8'h40;
	localparam logic [7:0] CMD_WR_LOCK   = 8'h20;
	localparam logic [7:0] CMD_WR_FLASH  = 8'h10;
	localparam logic [7:0] CMD_WR_EEPROM = 8'h11;
	localparam logic [7:0] CMD_RD_SIG    = 8'h08;
	localparam logic [7:0] CMD_RD_FUSE   = 8'h04;
	localparam logic [7:0] CMD_RD_FLASH  = 8'h02;
	localparam logic [7:0] CMD_RD_EEPROM = 8'h03;

	// Memory geometry
	localparam int FLASH_WORDS    = 2048;
	localparam int FLASH_AW       = 11;
	localparam int PAGE_WORDS     = 32;
	localparam int WORD_IN_PAGE_W = 5;
	localparam int PAGE_INDEX_W   = 6;
	localparam int EE_BYTES       = 64;
	localparam int EE_AW          = 6;
	localparam int EE_PAGE_BYTES  = 4;
	localparam int EE_BYTE_W      = 2;
	localparam int FIFO_DEPTH     = 16;
	localparam int FIFO_WIDTH     = 16;

	// Reset values
	localparam logic [7:0]  ERASED_BYTE    = 8'hff;
	localparam logic [15:0] ERASED_WORD    = 16'hffff;
	localparam logic [7:0]  FUSE_LO_RST    = 8'h62;
	localparam logic [7:0]  FUSE_HI_RST    = 8'hdf;
	localparam logic [7:0]  FUSE_EXT_RST   = 8'hff;
	localparam logic [7:0]  LOCK_RST       = 8'hff;
	localparam int          FUSE_KEEP_EE   = 3;
	// Arbitrary identity values
	localparam logic [7:0]  SIG_0          = 8'h5a;
	localparam logic [7:0]  SIG_1          = 8'h3c;
	localparam logic [7:0]  SIG_2          = 8'h11;
	localparam logic [7:0]  CAL_BYTE       = 8'h80;

	// Timing, in nanoseconds, in cycles of sys_clk or in rises of load_strobe
	localparam int CLK_PERIOD_NS   = 50;
	localparam int ENTRY_HOLD_NS   = 100;
	localparam int ENTRY_HOLD_CYC  = (ENTRY_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ENTRY_TOGGLES   = 6;
	localparam int OP_BUSY_CYC     = 64;

	typedef enum logic [2:0] {
		PPP_OFF    = 3'b000,
		PPP_ARM    = 3'b001,
		PPP_IDLE   = 3'b010,
		PPP_ERASE  = 3'b011,
		PPP_PROG   = 3'b100,
		PPP_EEPROG = 3'b101,
		PPP_NVM    = 3'b110
	} ppp_state_t;

endpackage : ppp_pkg

// ===== hdl/ppp_fifo.sv
// Module: parameterised valid/ready FIFO for page-buffer words
`timescale 1ns/1ps
`default_nettype none
module ppp_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input  wire logic             sys_clk,
	input  wire logic             sys_rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
	} ppp_fifo_st_t;

	ppp_fifo_st_t s_q, s_d;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push, pop;

	assign in_ready  = (s_q.cnt != DEPTH[AW:0]);
	assign out_valid = (s_q.cnt != '0);
	assign out_data  = mem[s_q.rp];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		s_d = s_q;
		if (push)
			s_d.wp = s_q.wp + 1'b1;
		if (pop)
			s_d.rp = s_q.rp + 1'b1;
		if (push && !pop)
			s_d.cnt = s_q.cnt + 1'b1;
		else if (pop && !push)
			s_d.cnt = s_q.cnt - 1'b1;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			s_q <= '0;
		else
			s_q <= s_d;
		if (push)
			mem[s_q.wp] <= in_data;
	end
endmodule : ppp_fifo
`default_nettype wire

// ===== hdl/ppp_port.sv
// Module: high-voltage parallel programming port with flash and EEPROM arrays
`timescale 1ns/1ps
`default_nettype none
module ppp_port (
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	input  wire logic       hv_reset_pin,
	input  wire logic       load_strobe,
	input  wire logic       action_sel_lo,
	input  wire logic       action_sel_hi,
	input  wire logic       byte_sel_first,
	input  wire logic       prog_pulse_n,
	input  wire logic       out_gate_n,
	input  wire logic [7:0] data_in,
	output logic      [7:0] data_out,
	output logic            data_oe,
	output logic            ready_busy_flag,
	output logic            prog_mode
);
	import ppp_pkg::*;

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	localparam int NPIN = 15;
	logic [NPIN-1:0] pin_raw, s1_q, s2_q, s3_q, pin_f;
	assign pin_raw = {data_in, out_gate_n, prog_pulse_n, byte_sel_first,
		action_sel_hi, action_sel_lo, load_strobe, hv_reset_pin};

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= pin_raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	logic            hv_f, ls_f, xa0_f, xa1_f, bs1_f, wr_n_f, oe_n_f;
	logic [7:0]      din_f;
	assign {din_f, oe_n_f, wr_n_f, bs1_f, xa1_f, xa0_f, ls_f, hv_f} = pin_f;

	// Decoded view: true when any entry-pattern pin is 1
	function automatic logic pattern_active(input logic [NPIN-1:0] p);
		return p[5] | p[4] | p[3] | p[2];
	endfunction

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [NPIN-1:0]       pin;
		ppp_state_t            st;
		logic [2:0]            toggles;
		logic [3:0]            hold;
		logic [7:0]            cmd;
		logic [7:0]            addr_hi;
		logic [7:0]            addr_lo;
		logic [7:0]            data_lo;
		logic [7:0]            fuse_lo;
		logic [7:0]            fuse_hi;
		logic [7:0]            fuse_ext;
		logic [7:0]            lock;
		logic [FLASH_AW:0]     idx;
		logic [7:0]            busy;
		logic [7:0]            dout;
		logic                  oe;
		logic                  rdy;
		logic                  mode;
	} ppp_st_t;

	ppp_st_t s_q, s_d;
	assign pin_f = s_q.pin;

	logic [15:0] flash_mem [FLASH_WORDS];
	logic [7:0]  ee_mem    [EE_BYTES];
	logic [15:0] page_buf  [PAGE_WORDS];
	logic [7:0]  ee_buf    [EE_PAGE_BYTES];

	logic [NPIN-1:0] pin_n;
	logic            ls_rise, wr_fall;
	// Per pin, a new level counts once the second and third stages agree
	assign pin_n   = ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & s_q.pin);
	// Edges compare the level about to be taken with the one held now
	assign ls_rise = pin_n[1] && !ls_f;
	assign wr_fall = !pin_n[5] && wr_n_f;

	// Page buffer words pass the FIFO and drain into the buffer in every state but PPP_PROG
	logic        f_in_valid, f_in_ready, f_out_valid, f_out_ready;
	logic [15:0] f_in_data, f_out_data;
	logic [WORD_IN_PAGE_W-1:0] wip_w;
	logic [FLASH_AW-1:0]       faddr;
	logic [EE_AW-1:0]          eaddr;
	assign faddr = {s_q.addr_hi[2:0], s_q.addr_lo};
	assign eaddr = s_q.addr_lo[EE_AW-1:0];
	assign f_in_data   = {din_f, s_q.data_lo};
	assign f_in_valid  = s_q.st == PPP_IDLE && ls_rise && {xa1_f, xa0_f} == ACT_DATA
		&& bs1_f && s_q.cmd == CMD_WR_FLASH;
	assign f_out_ready = s_q.st != PPP_PROG;

	ppp_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
		.sys_clk   (sys_clk),
		.sys_rst   (sys_rst),
		.in_valid  (f_in_valid),
		.in_ready  (f_in_ready),
		.in_data   (f_in_data),
		.out_valid (f_out_valid),
		.out_ready (f_out_ready),
		.out_data  (f_out_data)
	);

	// Word index travels with the data; slot taken from low address bits
	logic [WORD_IN_PAGE_W-1:0] slot_q [FIFO_DEPTH];
	logic [3:0]                sw_q, sr_q;
	assign wip_w = slot_q[sr_q];

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.pin = pin_n;
		if (s_q.busy != '0)
			s_d.busy = s_q.busy - 8'h01;
		case (s_q.st)
			PPP_OFF: begin
				s_d.hold = '0;
				s_d.idx = s_q.idx + 1'b1;
				if (!hv_f && ls_rise && s_q.toggles != 3'h7)
					s_d.toggles = s_q.toggles + 3'h1;
				if (hv_f && s_q.toggles >= 3'(ENTRY_TOGGLES)
						&& !pattern_active(s_q.pin))
					s_d.st = PPP_ARM;
				else if (hv_f)
					s_d.toggles = '0;
			end
			PPP_ARM: begin
				if (!hv_f || pattern_active(s_q.pin)) begin
					s_d.st = PPP_OFF;
					s_d.toggles = '0;
				end else if (s_q.hold == 4'(ENTRY_HOLD_CYC)) begin
					s_d.st = PPP_IDLE;
				end else begin
					s_d.hold = s_q.hold + 4'h1;
				end
			end
			PPP_IDLE: begin
				if (ls_rise) begin
					case ({xa1_f, xa0_f})
						ACT_ADDR: begin
							if (bs1_f)
								s_d.addr_hi = din_f;
							else
								s_d.addr_lo = din_f;
						end
						ACT_DATA: begin
							if (!bs1_f)
								s_d.data_lo = din_f;
						end
						ACT_CMD: s_d.cmd = din_f;
						default: ;
					endcase
				end else if (wr_fall) begin
					case (s_q.cmd)
						CMD_ERASE: begin
							s_d.st = PPP_ERASE;
							s_d.idx = '0;
						end
						CMD_WR_FLASH: begin
							s_d.st = PPP_PROG;
							s_d.idx = '0;
						end
						CMD_WR_EEPROM: begin
							s_d.st = PPP_EEPROG;
							s_d.idx = '0;
						end
						CMD_WR_FUSE: begin
							s_d.st = PPP_NVM;
							s_d.busy = 8'(OP_BUSY_CYC);
							if (bs1_f)
								s_d.fuse_hi = s_q.data_lo;
							else if (xa1_f)
								s_d.fuse_ext = s_q.data_lo;
							else
								s_d.fuse_lo = s_q.data_lo;
						end
						CMD_WR_LOCK: begin
							s_d.st = PPP_NVM;
							s_d.busy = 8'(OP_BUSY_CYC);
							s_d.lock = s_q.lock & s_q.data_lo;
						end
						default: ;
					endcase
				end
				if (!hv_f)
					s_d.st = PPP_OFF;
			end
			PPP_ERASE: begin
				s_d.idx = s_q.idx + 1'b1;
				if (s_q.idx == (FLASH_AW+1)'(FLASH_WORDS - 1)) begin
					s_d.lock = LOCK_RST;
					s_d.st = PPP_IDLE;
				end
			end
			PPP_PROG: begin
				s_d.idx = s_q.idx + 1'b1;
				if (s_q.idx == (FLASH_AW+1)'(PAGE_WORDS - 1))
					s_d.st = PPP_IDLE;
			end
			PPP_EEPROG: begin
				s_d.idx = s_q.idx + 1'b1;
				if (s_q.idx == (FLASH_AW+1)'(EE_PAGE_BYTES - 1))
					s_d.st = PPP_IDLE;
			end
			PPP_NVM: begin
				if (s_q.busy == '0)
					s_d.st = PPP_IDLE;
			end
			default: s_d.st = PPP_OFF;
		endcase
		s_d.rdy = (s_d.st == PPP_IDLE) && !f_out_valid;
		s_d.mode = (s_d.st != PPP_OFF) && (s_d.st != PPP_ARM);
		s_d.oe  = (s_q.st == PPP_IDLE) && !oe_n_f;
		s_d.dout = '0;
		case (s_q.cmd)
			CMD_RD_FLASH:  s_d.dout = bs1_f ? flash_mem[faddr][15:8] : flash_mem[faddr][7:0];
			CMD_RD_EEPROM: s_d.dout = ee_mem[eaddr];
			CMD_RD_SIG: begin
				if (bs1_f)
					s_d.dout = CAL_BYTE;
				else
					case (s_q.addr_lo[1:0])
						2'h0:    s_d.dout = SIG_0;
						2'h1:    s_d.dout = SIG_1;
						default: s_d.dout = SIG_2;
					endcase
			end
			CMD_RD_FUSE: begin
				case ({xa1_f, bs1_f})
					2'h0:    s_d.dout = s_q.fuse_lo;
					2'h3:    s_d.dout = s_q.fuse_hi;
					2'h2:    s_d.dout = s_q.fuse_ext;
					default: s_d.dout = s_q.lock;
				endcase
			end
			default: ;
		endcase
	end

	// ---------------------------------------------------------------
	// Registers and arrays
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			s_q <= '0;
			s_q.st <= PPP_OFF;
			s_q.fuse_lo <= FUSE_LO_RST;
			s_q.fuse_hi <= FUSE_HI_RST;
			s_q.fuse_ext <= FUSE_EXT_RST;
			s_q.lock <= LOCK_RST;
			s_q.pin <= '0;
			sw_q <= '0;
			sr_q <= '0;
		end else begin
			s_q <= s_d;
			if (f_in_valid && f_in_ready) begin
				slot_q[sw_q] <= s_q.addr_lo[WORD_IN_PAGE_W-1:0];
				sw_q <= sw_q + 4'h1;
			end
			if (f_out_valid && f_out_ready)
				sr_q <= sr_q + 4'h1;
		end
		if (f_out_valid && f_out_ready)
			page_buf[wip_w] <= f_out_data;
		if (s_q.st == PPP_IDLE && ls_rise && {xa1_f, xa0_f} == ACT_DATA && !bs1_f
				&& s_q.cmd == CMD_WR_EEPROM)
			ee_buf[s_q.addr_lo[EE_BYTE_W-1:0]] <= din_f;
		// Unloaded buffer slots read as erased: cleared off-mode, on erase and once written
		if (s_q.st == PPP_OFF || s_q.st == PPP_ERASE) begin
			page_buf[s_q.idx[WORD_IN_PAGE_W-1:0]] <= ERASED_WORD;
			ee_buf[s_q.idx[EE_BYTE_W-1:0]] <= ERASED_BYTE;
		end
		if (s_q.st == PPP_ERASE) begin
			flash_mem[s_q.idx[FLASH_AW-1:0]] <= ERASED_WORD;
			if (s_q.fuse_hi[FUSE_KEEP_EE] && s_q.idx < (FLASH_AW+1)'(EE_BYTES))
				ee_mem[s_q.idx[EE_AW-1:0]] <= ERASED_BYTE;
		end
		if (s_q.st == PPP_PROG) begin
			flash_mem[{faddr[FLASH_AW-1:WORD_IN_PAGE_W],
				s_q.idx[WORD_IN_PAGE_W-1:0]}] <= page_buf[s_q.idx[WORD_IN_PAGE_W-1:0]];
			page_buf[s_q.idx[WORD_IN_PAGE_W-1:0]] <= ERASED_WORD;
		end
		if (s_q.st == PPP_EEPROG) begin
			ee_mem[{eaddr[EE_AW-1:EE_BYTE_W], s_q.idx[EE_BYTE_W-1:0]}]
				<= ee_buf[s_q.idx[EE_BYTE_W-1:0]];
			ee_buf[s_q.idx[EE_BYTE_W-1:0]] <= ERASED_BYTE;
		end
	end

	assign data_out        = s_q.dout;
	assign data_oe         = s_q.oe;
	assign ready_busy_flag = s_q.rdy;
	assign prog_mode       = s_q.mode;
endmodule : ppp_port
`default_nettype wire

// ===== bench/ppp_port_chk.sv
// Checker: pin-level properties of the programming port
`timescale 1ns/1ps
`default_nettype none
module ppp_port_chk
	import ppp_pkg::*;
(
	input wire logic       sys_clk,
	input wire logic       sys_rst,
	input wire logic       hv_reset_pin,
	input wire logic       load_strobe,
	input wire logic       action_sel_lo,
	input wire logic       action_sel_hi,
	input wire logic       byte_sel_first,
	input wire logic       prog_pulse_n,
	input wire logic       out_gate_n,
	input wire logic [7:0] data_in,
	input wire logic [7:0] data_out,
	input wire logic       data_oe,
	input wire logic       ready_busy_flag,
	input wire logic       prog_mode
);
	// Shadow of the latched command and length of the current busy spell
	logic [7:0]  cmd_q;
	logic        strobe_q;
	logic [11:0] busy_q;
	logic        cmd_load;
	assign cmd_load = prog_mode && load_strobe && !strobe_q;
	always_ff @(posedge sys_clk) begin
		strobe_q <= load_strobe;
		busy_q <= (sys_rst || ready_busy_flag) ? 12'h000 : busy_q + 12'h001;
		if (sys_rst)
			cmd_q <= CMD_NOP;
		else if (cmd_load && {action_sel_hi, action_sel_lo} == ACT_CMD)
			cmd_q <= data_in;
	end
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);
	sequence s_hv_up;
		!prog_mode && $rose(hv_reset_pin);
	endsequence
	sequence s_pat_moved;
		{byte_sel_first, action_sel_hi, action_sel_lo, prog_pulse_n} != 4'h0;
	endsequence
	sequence s_op(logic [7:0] c);
		prog_mode && ready_busy_flag && $fell(prog_pulse_n) && cmd_q == c;
	endsequence
	chk_oe_gate_high: assert property (out_gate_n [*6] |-> !data_oe)
		else $error("bus driven with gate high");
	chk_oe_needs_mode: assert property (data_oe |-> prog_mode)
		else $error("bus driven outside programming mode");
	chk_oe_gate_low: assert property
		((prog_mode && ready_busy_flag && !out_gate_n) [*6] |-> data_oe)
		else $error("bus not driven with gate low");
	chk_entry_spoiled: assert property (s_hv_up ##1 s_pat_moved |-> !prog_mode [*8])
		else $error("entry taken despite pattern change");
	chk_entry_needs_hv: assert property
		($rose(prog_mode) |-> hv_reset_pin && $past(hv_reset_pin, 3))
		else $error("entry without programming voltage");
	chk_erase_busy: assert property (s_op(CMD_ERASE) |-> ##[1:8] !ready_busy_flag)
		else $error("erase did not go busy");
	chk_flash_busy: assert property (s_op(CMD_WR_FLASH) |-> ##[1:8] !ready_busy_flag)
		else $error("page program did not go busy");
	chk_nop_idle: assert property (s_op(CMD_NOP) |-> ready_busy_flag [*8])
		else $error("no-op pulse started an operation");
	chk_erase_len: assert property
		($rose(ready_busy_flag) && cmd_q == CMD_ERASE |-> busy_q >= 12'h800 && busy_q <= 12'h808)
		else $error("erase busy spell has wrong length");
endmodule : ppp_port_chk
bind ppp_port ppp_port_chk u_chk (.*);
`default_nettype wire

// ===== bench/ppp_prog_model.sv
// Partner model: external parallel programmer driving the port pins
`timescale 1ns/1ps
`default_nettype none
module ppp_prog_model
	import ppp_pkg::*;
(
	input  wire logic       sys_clk,
	output logic            hv_reset_pin,
	output logic            load_strobe,
	output logic            action_sel_lo,
	output logic            action_sel_hi,
	output logic            byte_sel_first,
	output logic            prog_pulse_n,
	output logic            out_gate_n,
	output logic      [7:0] data_drv
);
	initial begin
		hv_reset_pin = 1'b0;
		load_strobe = 1'b0;
		{action_sel_hi, action_sel_lo} = ACT_IDLE;
		byte_sel_first = 1'b0;
		prog_pulse_n = 1'b1;
		out_gate_n = 1'b1;
		data_drv = 8'h00;
	end
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : step
	// Every level stands six clocks, 300 ns
	task automatic put(input logic [1:0] act, input logic bs, input logic [7:0] val);
		{action_sel_hi, action_sel_lo} <= act;
		byte_sel_first <= bs;
		data_drv <= val;
		step(6);
		load_strobe <= 1'b1;
		step(6);
		load_strobe <= 1'b0;
		step(6);
	endtask : put
	task automatic pulse();
		prog_pulse_n <= 1'b0;
		step(6);
		prog_pulse_n <= 1'b1;
		step(6);
	endtask : pulse
	// Released lines wander so a stale value is never read back
	task automatic gate(input logic en_n, input logic bs);
		{action_sel_hi, action_sel_lo} <= ACT_ADDR;
		byte_sel_first <= bs;
		out_gate_n <= en_n;
		if (!en_n)
			data_drv <= ~data_drv;
		step(8);
	endtask : gate
	task automatic enter(input logic spoil);
		hv_reset_pin <= 1'b0;
		step(6);
		repeat (12) begin
			load_strobe <= ~load_strobe;
			step(6);
		end
		{byte_sel_first, action_sel_hi, action_sel_lo, prog_pulse_n} <= 4'h0;
		step(4);
		hv_reset_pin <= 1'b1;
		step(1);
		if (spoil)
			prog_pulse_n <= 1'b1;
		step(10);
		prog_pulse_n <= 1'b1;
		{action_sel_hi, action_sel_lo} <= ACT_IDLE;
		step(1000);
	endtask : enter
endmodule : ppp_prog_model
`default_nettype wire

// ===== bench/ppp_port_tb.sv
// Testbench: programming port driven through the programmer model
`timescale 1ns/1ps
`default_nettype none
module ppp_port_tb;
	import ppp_pkg::*;
	logic       sys_clk, sys_rst, hv_reset_pin, load_strobe, action_sel_lo, action_sel_hi;
	logic       byte_sel_first, prog_pulse_n, out_gate_n, data_oe, ready_busy_flag, prog_mode;
	logic       saw_busy;
	logic [7:0] data_in, data_out, data_drv;
	int         n_errors, n_compared;
	ppp_port uut (.*);
	ppp_prog_model prog (.*);
	assign data_in = (data_oe === 1'b1) ? data_out : data_drv;
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
		if (ready_busy_flag === 1'b0)
			saw_busy <= 1'b1;
	task automatic chk(input logic [8:0] seen, input logic [8:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
		end
	endtask : chk
	task automatic wrap_up();
		$display("errors %0d, compares %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up
	task automatic op(input logic busy);
		int i;
		saw_busy = 1'b0;
		prog.pulse();
		for (i = 0; i < 3000 && ready_busy_flag !== 1'b1; i++)
			@(posedge sys_clk);
		chk({8'h00, saw_busy}, {8'h00, busy}, "busy seen");
		chk({8'h00, ready_busy_flag}, 9'h001, "ready again");
	endtask : op
	task automatic rd(input logic bs, input logic [7:0] exp);
		prog.gate(1'b0, bs);
		chk({data_oe, data_out}, {1'b1, exp}, "read");
		prog.gate(1'b1, 1'b0);
		chk({8'h00, data_oe}, 9'h000, "bus released");
	endtask : rd
	task automatic cmd(input logic [7:0] c);
		prog.put(ACT_CMD, 1'b0, c);
	endtask : cmd
	task automatic ww(input logic [7:0] lo, input logic [15:0] w);
		prog.put(ACT_ADDR, 1'b0, lo);
		prog.put(ACT_DATA, 1'b0, w[7:0]);
		prog.put(ACT_DATA, 1'b1, w[15:8]);
		prog.put(ACT_IDLE, 1'b0, 8'hee);
	endtask : ww
	task automatic rw(input logic [7:0] lo, input logic [15:0] w);
		prog.put(ACT_ADDR, 1'b0, lo);
		rd(1'b0, w[7:0]);
		rd(1'b1, w[15:8]);
	endtask : rw
	task automatic fuse_hi(input logic [7:0] v);
		cmd(CMD_WR_FUSE);
		prog.put(ACT_DATA, 1'b0, v);
		prog.put(ACT_ADDR, 1'b1, 8'h00);
		op(1'b1);
	endtask : fuse_hi
	task automatic erase_chk(input logic [7:0] ee);
		cmd(CMD_ERASE);
		op(1'b1);
		cmd(CMD_RD_EEPROM);
		prog.put(ACT_ADDR, 1'b0, 8'h05);
		rd(1'b0, ee);
		cmd(CMD_RD_FUSE);
		rd(1'b0, FUSE_LO_RST);
		rd(1'b1, LOCK_RST);
	endtask : erase_chk
	task automatic t_entry();
		prog.enter(1'b1);
		chk({8'h00, prog_mode}, 9'h000, "spoiled entry");
		prog.enter(1'b0);
		chk({7'h00, prog_mode, ready_busy_flag}, 9'h003, "entry");
	endtask : t_entry
	task automatic t_sig();
		cmd(CMD_RD_SIG);
		prog.put(ACT_ADDR, 1'b1, 8'h00);
		prog.put(ACT_ADDR, 1'b0, 8'h00);
		rd(1'b0, SIG_0);
		rd(1'b1, CAL_BYTE);
	endtask : t_sig
	task automatic t_keep();
		cmd(CMD_WR_EEPROM);
		prog.put(ACT_ADDR, 1'b0, 8'h05);
		prog.put(ACT_DATA, 1'b0, 8'h5a);
		op(1'b1);
		cmd(CMD_WR_LOCK);
		prog.put(ACT_DATA, 1'b0, 8'hfc);
		op(1'b1);
		cmd(CMD_RD_FUSE);
		rd(1'b1, 8'hfc);
		fuse_hi(8'hd7);
		erase_chk(8'h5a);
	endtask : t_keep
	task automatic t_flash();
		cmd(CMD_WR_FLASH);
		ww(8'h20, 16'h1234);
		ww(8'h3f, 16'ha55a);
		prog.put(ACT_ADDR, 1'b1, 8'h04);
		op(1'b1);
		cmd(CMD_NOP);
		op(1'b0);
		cmd(CMD_RD_FLASH);
		rw(8'h20, 16'h1234);
		rw(8'h3f, 16'ha55a);
		rw(8'h21, ERASED_WORD);
		prog.put(ACT_ADDR, 1'b1, 8'h00);
		rw(8'h20, ERASED_WORD);
	endtask : t_flash
	initial begin
		n_errors = 0;
		n_compared = 0;
		saw_busy = 1'b0;
		sys_rst = 1'b1;
		repeat (3) @(posedge sys_clk);
		sys_rst <= 1'b0;
		t_entry();
		t_sig();
		t_keep();
		fuse_hi(FUSE_HI_RST);
		erase_chk(ERASED_BYTE);
		t_flash();
		wrap_up();
	end
	initial begin
		#(20000 * 50);
		n_errors++;
		$display("[FAIL] %0t watchdog expired", $time);
		wrap_up();
	end
endmodule : ppp_port_tb
`default_nettype wire
